// ==== logic/ccbd_device_end.sv ====
// Device end: decodes control bytes into codec settings and derived gains.
// Assumes one byte per strobe, on mclk, from the host end through the link.
`timescale 1ns/1ps
`include "ccbd_defines.svh"
module ccbd_device_end (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Link
    ccbd_link_if.dev link,
    // Converter power
    output logic [1:0] power_switch,
    output logic play_conv_on,
    output logic rec_conv_on,
    // Playback settings
    output logic [5:0] volume_step,
    output logic [5:0] volume_atten_db,
    output logic volume_silent,
    output logic [3:0] bass_boost,
    output logic [1:0] high_shelf_gain,
    output ccbd_pkg::ccbd_curve_e tone_curve,
    output logic [4:0] bass_db,
    output logic [2:0] shelf_db,
    output logic peak_tap_select,
    output logic [1:0] emphasis_undo,
    output logic emphasis_on,
    output logic mute_bit,
    output logic play_silence,
    // Extended settings
    output logic [2:0] ext_addr,
    output logic [4:0] mix_coef_one,
    output logic [4:0] mix_coef_two,
    output logic [6:0] mix_one_atten_half_db,
    output logic [6:0] mix_two_atten_half_db,
    output logic mix_one_block,
    output logic mix_two_block,
    output ccbd_pkg::ccbd_mix_src_e mixer_source_select,
    output logic mix_use_one,
    output logic mix_use_two,
    output logic [2:0] mic_preamp_gain,
    output logic signed [5:0] mic_gain_db,
    output logic mic_gain_active,
    output logic gain_loop_enable,
    output logic [6:0] channel_two_gain,
    output logic signed [7:0] ch2_gain_half_db,
    output logic ch2_manual_active,
    output logic [2:0] gain_loop_timing,
    output logic [1:0] target_output_level,
    output logic [5:0] target_below_fs_half_db,
    output logic [4:0] attack_ms,
    output logic [8:0] decay_ms
);
    logic data_wr;
    logic [1:0] group;
    logic payload_wr;
    logic [4:0] ext_payload;
    logic [4:0] bass_db_c;
    logic [2:0] shelf_db_c;

    assign data_wr = link.wr_stb && (link.control_write_type == ccbd_pkg::CCBD_TYPE_DATA);
    assign group = link.wr_byte[7:6];
    assign payload_wr = data_wr && group == `CCBD_GROUP_EXT && link.wr_byte[`CCBD_EXT_PAYLOAD_BIT];
    assign ext_payload = link.wr_byte[4:0]; // see RULE_06

    // ==========================================================================
    // Power control
    // Only the status byte with its top bit set carries power; the other status byte is ignored here.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            power_switch <= `CCBD_RST_POWER;
        end else if (link.wr_stb && link.control_write_type == ccbd_pkg::CCBD_TYPE_STATUS
                     && link.wr_byte[`CCBD_STATUS_POWER_BIT]) begin
            power_switch <= link.wr_byte[1:0];
        end
    end
    assign play_conv_on = power_switch[0]; // see RULE_01
    assign rec_conv_on = power_switch[1]; // see RULE_01

    // ==========================================================================
    // Direct groups
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            volume_step <= `CCBD_RST_VOLUME;
            bass_boost <= `CCBD_RST_BASS;
            high_shelf_gain <= `CCBD_RST_SHELF;
            peak_tap_select <= `CCBD_RST_PEAK_TAP;
            emphasis_undo <= `CCBD_RST_EMPHASIS;
            mute_bit <= `CCBD_RST_MUTE;
            tone_curve <= ccbd_pkg::ccbd_curve_e'(`CCBD_RST_CURVE);
        end else if (data_wr) begin
            if (group == `CCBD_GROUP_VOLUME) begin
                volume_step <= link.wr_byte[5:0]; // see RULE_02
            end else if (group == `CCBD_GROUP_TONE) begin
                bass_boost <= link.wr_byte[5:2]; // see RULE_03
                high_shelf_gain <= link.wr_byte[1:0]; // see RULE_03
            end else if (group == `CCBD_GROUP_MISC) begin
                peak_tap_select <= link.wr_byte[5]; // see RULE_04 and RULE_12
                emphasis_undo <= link.wr_byte[4:3]; // see RULE_04
                mute_bit <= link.wr_byte[2]; // see RULE_04
                tone_curve <= ccbd_pkg::ccbd_curve_e'(link.wr_byte[1:0]); // see RULE_04
            end
        end
    end

    // ==========================================================================
    // Extended address and registers
    // A byte 11 with nonzero bits 5 to 3 but bit 5 clear matches neither form and is dropped.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ext_addr <= `CCBD_RST_EXT_ADDR;
        end else if (data_wr && group == `CCBD_GROUP_EXT && link.wr_byte[5:3] == `CCBD_EXT_ADDR_PAD) begin
            ext_addr <= link.wr_byte[2:0]; // see RULE_05
        end
    end

    // The address stays after a payload, so repeated payloads go to the same register.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mix_coef_one <= `CCBD_RST_MIX_COEF;
            mix_coef_two <= `CCBD_RST_MIX_COEF;
            mic_preamp_gain <= `CCBD_RST_MIC_GAIN;
            mixer_source_select <= ccbd_pkg::ccbd_mix_src_e'(`CCBD_RST_MIX_SRC);
            gain_loop_enable <= `CCBD_RST_LOOP_EN;
            channel_two_gain <= `CCBD_RST_CH2_GAIN;
            gain_loop_timing <= `CCBD_RST_TIMING;
            target_output_level <= `CCBD_RST_LEVEL;
        end else if (payload_wr) begin // see RULE_07
            if (ext_addr == `CCBD_EA_MIX_ONE) begin
                mix_coef_one <= ext_payload; // see RULE_15
            end else if (ext_addr == `CCBD_EA_MIX_TWO) begin
                mix_coef_two <= ext_payload; // see RULE_15
            end else if (ext_addr == `CCBD_EA_MIC_SRC) begin
                mic_preamp_gain <= ext_payload[4:2]; // see RULE_15
                mixer_source_select <= ccbd_pkg::ccbd_mix_src_e'(ext_payload[1:0]);
            end else if (ext_addr == `CCBD_EA_LOOP_LOW) begin
                gain_loop_enable <= ext_payload[4]; // see RULE_15
                channel_two_gain[1:0] <= ext_payload[1:0]; // see RULE_20
            end else if (ext_addr == `CCBD_EA_GAIN_HIGH) begin
                channel_two_gain[6:2] <= ext_payload; // see RULE_20
            end else if (ext_addr == `CCBD_EA_TIMING) begin
                gain_loop_timing <= ext_payload[4:2]; // see RULE_15
                target_output_level <= ext_payload[1:0];
            end
            // Addresses 011 and 111 fall through and change nothing. see RULE_24
        end
    end

    // ==========================================================================
    // Derived values
    ccbd_tone_map u_tone_map (
        .curve(tone_curve),
        .bass_code(bass_boost),
        .shelf_code(high_shelf_gain),
        .bass_db(bass_db_c),
        .shelf_db(shelf_db_c)
    );

    // Derived values other than emphasis_on, play_silence, mix_use_one and mix_use_two are registered once more, so they trail their codes by one cycle.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            volume_atten_db <= 6'h00;
            volume_silent <= 1'b0;
            bass_db <= 5'h00;
            shelf_db <= 3'h0;
        end else begin
            volume_silent <= (volume_step >= `CCBD_VOL_SILENT_FROM); // see RULE_08
            if (volume_step == 6'h00) begin
                volume_atten_db <= 6'h00; // see RULE_08
            end else begin
                volume_atten_db <= volume_step - 6'h01; // see RULE_08
            end
            bass_db <= bass_db_c; // see RULE_09
            shelf_db <= shelf_db_c; // see RULE_10
        end
    end

    assign emphasis_on = (emphasis_undo != 2'h0); // see RULE_13
    assign play_silence = mute_bit; // see RULE_14

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mix_one_atten_half_db <= 7'h00;
            mix_two_atten_half_db <= 7'h00;
            mix_one_block <= 1'b0;
            mix_two_block <= 1'b0;
        end else begin
            mix_one_atten_half_db <= 7'({2'b00, mix_coef_one} * `CCBD_MIX_STEP_HALF_DB); // see RULE_16
            mix_two_atten_half_db <= 7'({2'b00, mix_coef_two} * `CCBD_MIX_STEP_HALF_DB); // see RULE_16
            mix_one_block <= (mix_coef_one == `CCBD_MIX_BLOCK); // see RULE_16
            mix_two_block <= (mix_coef_two == `CCBD_MIX_BLOCK); // see RULE_16
        end
    end

    assign mix_use_one = mixer_source_select[0]; // see RULE_17
    assign mix_use_two = mixer_source_select[1]; // see RULE_17

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mic_gain_db <= 6'sh00;
            mic_gain_active <= 1'b0;
            ch2_gain_half_db <= 8'sh00;
            ch2_manual_active <= 1'b0;
        end else begin
            case (mic_preamp_gain)
                3'h0: mic_gain_db <= -6'sd3; // see RULE_18
                3'h1: mic_gain_db <= 6'sd0;
                3'h2: mic_gain_db <= 6'sd3;
                3'h3: mic_gain_db <= 6'sd9;
                3'h4: mic_gain_db <= 6'sd15;
                3'h5: mic_gain_db <= 6'sd21;
                3'h6: mic_gain_db <= 6'sd27;
                default: mic_gain_db <= 6'sd0;
            endcase
            mic_gain_active <= gain_loop_enable && mic_preamp_gain != `CCBD_MIC_UNUSED
                               && mixer_source_select != ccbd_pkg::CCBD_SRC_DOUBLE_DIFF; // see RULE_18
            ch2_gain_half_db <= $signed({1'b0, channel_two_gain}) - $signed(`CCBD_CH2_OFFSET_HALF_DB); // see RULE_22
            ch2_manual_active <= !gain_loop_enable
                                 && mixer_source_select != ccbd_pkg::CCBD_SRC_DOUBLE_DIFF; // see RULE_19
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            target_below_fs_half_db <= 6'h00;
            attack_ms <= 5'h00;
            decay_ms <= 9'h000;
        end else begin
            case (target_output_level)
                2'h0: target_below_fs_half_db <= 6'd18; // see RULE_21
                2'h1: target_below_fs_half_db <= 6'd23;
                2'h2: target_below_fs_half_db <= 6'd30;
                default: target_below_fs_half_db <= 6'd35;
            endcase
            case (gain_loop_timing)
                3'h0: attack_ms <= 5'd11; // see RULE_23
                3'h1: attack_ms <= 5'd16;
                3'h2: attack_ms <= 5'd11;
                3'h3: attack_ms <= 5'd16;
                3'h4: attack_ms <= 5'd21;
                3'h5: attack_ms <= 5'd11;
                3'h6: attack_ms <= 5'd16;
                default: attack_ms <= 5'd21;
            endcase
            if (gain_loop_timing < 3'h2) begin
                decay_ms <= 9'd100; // see RULE_23
            end else if (gain_loop_timing < 3'h5) begin
                decay_ms <= 9'd200;
            end else begin
                decay_ms <= 9'd400;
            end
        end
    end
endmodule // ccbd_device_end

// ==== common/ccbd_defines.svh ====
// Constants of the codec control byte decoder: field positions, codes, reset values and tables.
// Assumes inclusion by bare name from every design file that decodes or builds control bytes.
// What this block does
// (RULE_01) Power field gates playback and record converters.
// (RULE_02) Top bits 00 load six-bit volume step.
// (RULE_03) Top bits 01 load bass and shelf codes.
// (RULE_04) Top bits 10 load tap, emphasis, mute, curve.
// (RULE_05) Top bits 11000 store three-bit extended address.
// (RULE_06) Top bits 111 carry five-bit extended payload.
// (RULE_07) Address byte then payload selects extended register.
// (RULE_08) Volume: codes 0,1 zero dB, 62+ silence.
// (RULE_09) Bass: flat zero, min cap 18, max 24.
// (RULE_10) Shelf: flat zero, otherwise 0,2,4,6 dB.
// (RULE_11) Curve: 00 flat, 01/10 minimum, 11 maximum.
// (RULE_12) Peak tap: 0 before tone, 1 after.
// (RULE_13) Emphasis undo: bypass, 32, 44.1, 48 kHz.
// (RULE_14) Mute bit silences digital playback signal.
// (RULE_15) Extended addresses map to their six registers.
// (RULE_16) Mixer coefficient: 1.5 dB steps, 11111 blocks.
// (RULE_17) Mixer source: differential, one, two, weighted sum.
// (RULE_18) Mic gain table; active with loop, non-differential.
// (RULE_19) Loop off: manual gain; on: automatic plus mic.
// (RULE_20) Channel-two gain assembled from two writes.
// (RULE_21) Target level -9.0/-11.5/-15.0/-17.5 dB FS.
// (RULE_22) Channel-two gain -3 dB plus half-dB steps.
// (RULE_23) Timing code selects attack and decay pair.
// (RULE_24) Payloads to unassigned addresses are ignored.
`ifndef CCBD_DEFINES_SVH
`define CCBD_DEFINES_SVH

// ==========================================================================
// Byte layout
`define CCBD_GROUP_VOLUME 2'b00
`define CCBD_GROUP_TONE 2'b01
`define CCBD_GROUP_MISC 2'b10
`define CCBD_GROUP_EXT 2'b11
`define CCBD_EXT_PAYLOAD_BIT 5
`define CCBD_EXT_ADDR_PAD 3'b000
`define CCBD_STATUS_POWER_BIT 7

// ==========================================================================
// Extended addresses
`define CCBD_EA_MIX_ONE 3'b000
`define CCBD_EA_MIX_TWO 3'b001
`define CCBD_EA_MIC_SRC 3'b010
`define CCBD_EA_LOOP_LOW 3'b100
`define CCBD_EA_GAIN_HIGH 3'b101
`define CCBD_EA_TIMING 3'b110

// ==========================================================================
// Reset values
`define CCBD_RST_POWER 2'b11
`define CCBD_RST_VOLUME 6'h00
`define CCBD_RST_BASS 4'h0
`define CCBD_RST_SHELF 2'h0
`define CCBD_RST_PEAK_TAP 1'b1
`define CCBD_RST_EMPHASIS 2'h0
`define CCBD_RST_MUTE 1'b0
`define CCBD_RST_CURVE 2'h0
`define CCBD_RST_MIX_COEF 5'h04
`define CCBD_RST_MIC_GAIN 3'h1
`define CCBD_RST_MIX_SRC 2'h0
`define CCBD_RST_LOOP_EN 1'b0
`define CCBD_RST_CH2_GAIN 7'h00
`define CCBD_RST_TIMING 3'h0
`define CCBD_RST_LEVEL 2'h0
`define CCBD_RST_EXT_ADDR 3'h0

// ==========================================================================
// Value tables
`define CCBD_VOL_SILENT_FROM 6'h3e
`define CCBD_BASS_CAP_MIN 5'h12
`define CCBD_BASS_CAP_MAX 5'h18
`define CCBD_MIX_BLOCK 5'h1f
`define CCBD_MIX_STEP_HALF_DB 7'h03
`define CCBD_MIC_UNUSED 3'h7
`define CCBD_CH2_OFFSET_HALF_DB 8'h06

`endif

// ==== common/ccbd_pkg.sv ====
// Types shared by both ends of the codec control byte decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ccbd_pkg;

    typedef enum logic [1:0] {
        CCBD_CURVE_FLAT = 2'b00,
        CCBD_CURVE_MIN = 2'b01,
        CCBD_CURVE_MIN_ALT = 2'b10,
        CCBD_CURVE_MAX = 2'b11
    } ccbd_curve_e;

    typedef enum logic [1:0] {
        CCBD_SRC_DOUBLE_DIFF = 2'b00,
        CCBD_SRC_IN_ONE = 2'b01,
        CCBD_SRC_IN_TWO = 2'b10,
        CCBD_SRC_MIXED = 2'b11
    } ccbd_mix_src_e;

    // Kind of request the user gives the host end.
    typedef enum logic [1:0] {
        CCBD_REQ_POWER = 2'b00,
        CCBD_REQ_DIRECT = 2'b01,
        CCBD_REQ_EXT = 2'b10,
        CCBD_REQ_NONE = 2'b11
    } ccbd_req_e;

    // Control write type carried with each byte.
    typedef enum logic {
        CCBD_TYPE_STATUS = 1'b0,
        CCBD_TYPE_DATA = 1'b1
    } ccbd_wtype_e;

    typedef enum logic {
        CCBD_HOST_IDLE = 1'b0,
        CCBD_HOST_PAYLOAD = 1'b1
    } ccbd_host_state_e;

endpackage

// ==== common/ccbd_link_if.sv ====
// Byte-write link between the host end and the device end.
// Assumes both ends run on the same mclk; the link carries no clock.
`timescale 1ns/1ps
interface ccbd_link_if;
    logic wr_stb;
    logic [7:0] wr_byte;
    ccbd_pkg::ccbd_wtype_e control_write_type;

    modport host (output wr_stb, output wr_byte, output control_write_type);
    modport dev (input wr_stb, input wr_byte, input control_write_type);
endinterface

// ==== logic/ccbd_tone_map.sv ====
// Tone curve to bass boost and high-shelf gain in dB.
// Assumes registered codes at its inputs; it is purely combinational.
`timescale 1ns/1ps
`include "ccbd_defines.svh"
module ccbd_tone_map (
    // Codes
    input wire ccbd_pkg::ccbd_curve_e curve,
    input wire logic [3:0] bass_code,
    input wire logic [1:0] shelf_code,
    // Gains in dB
    output logic [4:0] bass_db,
    output logic [2:0] shelf_db
);
    logic [4:0] raw_bass;

    always_comb begin
        raw_bass = {bass_code, 1'b0};
        case (curve)
            ccbd_pkg::CCBD_CURVE_FLAT: begin
                bass_db = 5'h00; // see RULE_09
                shelf_db = 3'h0; // see RULE_10
            end
            ccbd_pkg::CCBD_CURVE_MAX: begin
                bass_db = (raw_bass > `CCBD_BASS_CAP_MAX) ? `CCBD_BASS_CAP_MAX : raw_bass; // see RULE_09
                shelf_db = {shelf_code, 1'b0}; // see RULE_10
            end
            default: begin
                // Both minimum codes share one curve.
                bass_db = (raw_bass > `CCBD_BASS_CAP_MIN) ? `CCBD_BASS_CAP_MIN : raw_bass; // see RULE_11
                shelf_db = {shelf_code, 1'b0}; // see RULE_10
            end
        endcase
    end
endmodule // ccbd_tone_map

// ==== logic/ccbd_host_end.sv ====
// Host end: turns user requests into control bytes on the link.
// Assumes the device end samples every strobe; there is no back-pressure from the link.
`timescale 1ns/1ps
`include "ccbd_defines.svh"
module ccbd_host_end (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Link
    ccbd_link_if.host link,
    // User requests
    input wire logic req_valid,
    output logic req_ready,
    input wire ccbd_pkg::ccbd_req_e req_kind,
    input wire logic [7:0] req_data,
    input wire logic [2:0] req_addr
);
    ccbd_pkg::ccbd_host_state_e state_ff;
    logic [4:0] payload_ff;
    logic stb_ff;
    logic [7:0] byte_ff;
    ccbd_pkg::ccbd_wtype_e type_ff;
    logic take;

    assign req_ready = (state_ff == ccbd_pkg::CCBD_HOST_IDLE);
    assign take = req_valid && req_ready;
    assign link.wr_stb = stb_ff;
    assign link.wr_byte = byte_ff;
    assign link.control_write_type = type_ff;

    // ==========================================================================
    // Sequencing
    // The extended payload always follows its address on the very next cycle.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_ff <= ccbd_pkg::CCBD_HOST_IDLE;
            payload_ff <= 5'h00;
        end else begin
            case (state_ff)
                ccbd_pkg::CCBD_HOST_IDLE: begin
                    if (take && req_kind == ccbd_pkg::CCBD_REQ_EXT) begin
                        state_ff <= ccbd_pkg::CCBD_HOST_PAYLOAD; // see RULE_07
                        payload_ff <= req_data[4:0];
                    end
                end
                default: begin
                    state_ff <= ccbd_pkg::CCBD_HOST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================================
    // Byte building
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            stb_ff <= 1'b0;
            byte_ff <= 8'h00;
            type_ff <= ccbd_pkg::CCBD_TYPE_STATUS;
        end else if (state_ff == ccbd_pkg::CCBD_HOST_PAYLOAD) begin
            stb_ff <= 1'b1;
            byte_ff <= {`CCBD_GROUP_EXT, 1'b1, payload_ff}; // see RULE_06
            type_ff <= ccbd_pkg::CCBD_TYPE_DATA;
        end else if (take && req_kind == ccbd_pkg::CCBD_REQ_POWER) begin
            stb_ff <= 1'b1;
            byte_ff <= {1'b1, 5'h00, req_data[1:0]}; // see RULE_01
            type_ff <= ccbd_pkg::CCBD_TYPE_STATUS;
        end else if (take && req_kind == ccbd_pkg::CCBD_REQ_DIRECT) begin
            stb_ff <= 1'b1;
            byte_ff <= req_data; // see RULE_02
            type_ff <= ccbd_pkg::CCBD_TYPE_DATA;
        end else if (take && req_kind == ccbd_pkg::CCBD_REQ_EXT) begin
            stb_ff <= 1'b1;
            byte_ff <= {`CCBD_GROUP_EXT, `CCBD_EXT_ADDR_PAD, req_addr}; // see RULE_05
            type_ff <= ccbd_pkg::CCBD_TYPE_DATA;
        end else begin
            stb_ff <= 1'b0;
        end
    end
endmodule // ccbd_host_end

// ==== test/ccbd_monitor.sv ====
// Checker for the link and the main device settings.
// Assumes instantiation beside the link interface.
`timescale 1ns/1ps
module ccbd_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Link
    input wire logic wr_stb,
    input wire logic [7:0] wr_byte,
    input wire ccbd_pkg::ccbd_wtype_e control_write_type,
    // Device settings
    input wire logic [1:0] power_switch,
    input wire logic play_conv_on,
    input wire logic rec_conv_on,
    input wire logic [5:0] volume_step,
    input wire logic volume_silent,
    input wire logic peak_tap_select,
    input wire logic [1:0] emphasis_undo,
    input wire logic mute_bit,
    input wire logic play_silence,
    input wire logic emphasis_on,
    input wire logic [2:0] ext_addr,
    input wire logic [4:0] mix_coef_one
);
    // ==========================================================================
    // Assertions
    wire data_stb = wr_stb && control_write_type == ccbd_pkg::CCBD_TYPE_DATA;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_volume_load: assert property (data_stb && wr_byte[7:6] == 2'b00 |=> volume_step == $past(wr_byte[5:0]))
        else $error("volume step not loaded");
    a_power_load: assert property (wr_stb && control_write_type == ccbd_pkg::CCBD_TYPE_STATUS && wr_byte[7]
        |=> power_switch == $past(wr_byte[1:0])) else $error("power field not loaded");
    a_conv_gate: assert property (play_conv_on == power_switch[0] && rec_conv_on == power_switch[1])
        else $error("converter gating wrong");
    a_misc_load: assert property (data_stb && wr_byte[7:6] == 2'b10
        |=> {peak_tap_select, emphasis_undo, mute_bit} == $past(wr_byte[5:2])) else $error("misc group not loaded");
    a_mute_path: assert property (play_silence == mute_bit && emphasis_on == (emphasis_undo != 2'b00))
        else $error("mute or emphasis flag wrong");
    a_addr_load: assert property (data_stb && wr_byte[7:3] == 5'b11000 |=> ext_addr == $past(wr_byte[2:0]))
        else $error("extended address not stored");
    a_mix_one_pay: assert property (data_stb && wr_byte[7:5] == 3'b111 && ext_addr == 3'b000
        |=> mix_coef_one == $past(wr_byte[4:0])) else $error("payload not stored");
    a_silent_flag: assert property (volume_silent == ($past(volume_step) >= 6'h3e))
        else $error("silence flag wrong");
endmodule // ccbd_monitor

// ==== test/codec_control_byte_decoder_tb_top.sv ====
// Bench: host and device ends joined by the link.
// Assumes design files and monitor compile first.
`timescale 1ns/1ps
module codec_control_byte_decoder_tb_top;
    // ==========================================================================
    // Signals
    logic mclk, nrst, req_valid, req_ready, play_conv_on, rec_conv_on, volume_silent, peak_tap_select;
    logic emphasis_on, mute_bit, play_silence, mix_one_block, mix_two_block, mix_use_one, mix_use_two;
    logic mic_gain_active, gain_loop_enable, ch2_manual_active;
    logic [1:0] power_switch, high_shelf_gain, emphasis_undo, target_output_level;
    logic [2:0] req_addr, shelf_db, ext_addr, mic_preamp_gain, gain_loop_timing;
    logic [3:0] bass_boost;
    logic [4:0] bass_db, mix_coef_one, mix_coef_two, attack_ms;
    logic [5:0] volume_step, volume_atten_db, target_below_fs_half_db;
    logic [6:0] mix_one_atten_half_db, mix_two_atten_half_db, channel_two_gain;
    logic [7:0] req_data;
    logic [8:0] decay_ms;
    logic signed [5:0] mic_gain_db;
    logic signed [7:0] ch2_gain_half_db;
    ccbd_pkg::ccbd_curve_e tone_curve;
    ccbd_pkg::ccbd_mix_src_e mixer_source_select;
    ccbd_pkg::ccbd_req_e req_kind;
    int n_errors = 0;
    int n_checks = 0;
    logic [5:0] vcodes [6] = '{6'h00, 6'h01, 6'h02, 6'h3d, 6'h3e, 6'h3f};

    ccbd_link_if link ();
    ccbd_host_end u_ccbd_host_end (.*);
    ccbd_device_end u_ccbd_device_end (.*);
    ccbd_monitor u_ccbd_monitor (.mclk, .nrst, .wr_stb(link.wr_stb), .wr_byte(link.wr_byte),
        .control_write_type(link.control_write_type), .power_switch, .play_conv_on, .rec_conv_on, .volume_step,
        .volume_silent, .peak_tap_select, .emphasis_undo, .mute_bit, .play_silence, .emphasis_on, .ext_addr,
        .mix_coef_one);

    // ==========================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Raised at a falling edge and dropped one cycle later.
    task automatic send(input ccbd_pkg::ccbd_req_e k, input logic [7:0] d, input logic [2:0] a = 3'h0);
        @(negedge mclk);
        while (req_ready !== 1'b1)
            @(negedge mclk);
        req_valid = 1'b1;
        req_kind = k;
        req_data = d;
        req_addr = a;
        @(negedge mclk);
        chk(req_ready, k != ccbd_pkg::CCBD_REQ_EXT);
        req_valid = 1'b0;
    endtask

    // Strobe, code edge and derived edge.
    task automatic settle();
        repeat (4) @(negedge mclk);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================================
    // Clock, watchdog and tests
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        test_done();
    end

    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req_kind = ccbd_pkg::CCBD_REQ_NONE;
        req_data = 8'h00;
        req_addr = 3'h0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        settle();
        chk({power_switch, peak_tap_select, mix_coef_one, mic_preamp_gain}, {2'b11, 1'b1, 5'h04, 3'h1});
        chk({attack_ms, decay_ms, target_below_fs_half_db}, {5'd11, 9'd100, 6'd18});
        for (int p = 0; p < 4; p++) begin
            send(ccbd_pkg::CCBD_REQ_POWER, 8'(p));
            settle();
            chk({play_conv_on, rec_conv_on, power_switch}, {p[0], p[1], p[1:0]});
        end
        foreach (vcodes[i]) begin
            send(ccbd_pkg::CCBD_REQ_DIRECT, {2'b00, vcodes[i]});
            settle();
            chk({volume_step, volume_silent}, {vcodes[i], vcodes[i] >= 6'h3e});
            if (vcodes[i] < 6'h3e)
                chk(volume_atten_db, (vcodes[i] < 6'h02) ? 6'h00 : vcodes[i] - 6'h01);
        end
        send(ccbd_pkg::CCBD_REQ_DIRECT, 8'h73);
        for (int c = 0; c < 4; c++) begin
            send(ccbd_pkg::CCBD_REQ_DIRECT, {2'b10, c[0], c[1:0], c[1], c[1:0]});
            settle();
            chk({bass_boost, high_shelf_gain, bass_db, shelf_db}, {4'hc, 2'h3,
                (c == 0) ? 5'd0 : (c == 3) ? 5'd24 : 5'd18, (c == 0) ? 3'd0 : 3'd6});
            chk({peak_tap_select, emphasis_undo, mute_bit, play_silence, emphasis_on, tone_curve},
                {c[0], c[1:0], c[1], c[1], c != 0, c[1:0]});
        end
        for (int a = 0; a < 8; a++)
            send(ccbd_pkg::CCBD_REQ_EXT, 8'(a + 8), 3'(a));
        settle();
        chk({mix_coef_one, mix_coef_two, mix_one_atten_half_db, mix_two_atten_half_db, mix_two_block},
            {5'd8, 5'd9, 7'd24, 7'd27, 1'b0});
        chk({mic_preamp_gain, mixer_source_select, mic_gain_db, mic_gain_active}, {3'd2, 2'd2, 6'd3, 1'b0});
        chk({gain_loop_enable, channel_two_gain, ch2_gain_half_db, ch2_manual_active},
            {1'b0, 7'd52, 8'd46, 1'b1});
        chk({gain_loop_timing, target_output_level, attack_ms, decay_ms, target_below_fs_half_db},
            {3'd3, 2'd2, 5'd16, 9'd200, 6'd30});
        send(ccbd_pkg::CCBD_REQ_EXT, 8'h13, 3'h4);
        settle();
        chk({gain_loop_enable, channel_two_gain, ch2_manual_active}, {1'b1, 7'd55, 1'b0});
        for (int s = 0; s < 4; s++) begin
            send(ccbd_pkg::CCBD_REQ_EXT, 8'(8 + s), 3'h2);
            settle();
            chk({mix_use_one, mix_use_two, mic_gain_active}, {s[0], s[1], s != 0});
        end
        send(ccbd_pkg::CCBD_REQ_EXT, 8'h1f, 3'h0);
        send(ccbd_pkg::CCBD_REQ_DIRECT, 8'hc5);
        send(ccbd_pkg::CCBD_REQ_DIRECT, 8'he4);
        send(ccbd_pkg::CCBD_REQ_DIRECT, 8'hc8);
        send(ccbd_pkg::CCBD_REQ_NONE, 8'h00);
        settle();
        chk({mix_coef_one, mix_one_block}, {5'h1f, 1'b1});
        chk({channel_two_gain, ext_addr, volume_step}, {7'd19, 3'd5, 6'h3f});
        test_done();
    end
endmodule // codec_control_byte_decoder_tb_top
